// ==== hw/mtcu_ctrl.sv ====
// tape control unit: command sequencing, checks, indicators and status tests
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module mtcu_ctrl
  import mtcu_pkg::*;
#(
  parameter int NUNITS    = 8,
  parameter int WR_TO     = WR_TO_CYC
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic [DATA_W-1:0]      bus_rdata,
  input  wire logic              test_valid,
  input  wire mtcu_test_t        test_kind,
  input  wire logic [2:0]        test_unit,
  output logic                   test_skip,
  input  wire logic [NUNITS-1:0] unit_present,
  input  wire logic [NUNITS-1:0] unit_auto,
  input  wire logic [NUNITS-1:0] unit_ring,
  input  wire logic [NUNITS-1:0] unit_load_pt,
  input  wire logic [NUNITS-1:0] unit_busy,
  input  wire logic [NUNITS-1:0] eor_sense,
  output logic                   tape_fwd,
  output logic                   tape_rev,
  output logic [2:0]             tape_unit,
  output logic                   tape_rec,
  output logic                   tape_wstb,
  output logic [6:0]             tape_wchar,
  input  wire logic              tape_rvalid,
  input  wire logic [6:0]        tape_rchar,
  input  wire logic              tape_gap,
  input  wire logic              tape_raw_chk,
  output logic                   ch_word_valid,
  output logic [WORD_W-1:0]      ch_word,
  input  wire logic              ch_char_valid,
  input  wire logic [CHR_W-1:0]  ch_char,
  input  wire logic              ch_term,
  output logic                   ch_gap,
  output logic                   ch_disc,
  output logic                   ch_err,
  output logic                   ch_word_end_int,
  output logic                   ch_eot_int
);

  localparam int TO_W = $clog2(WR_TO + 1);

  if (NUNITS < 1 || NUNITS > 8) begin : g_bad_units
    $error("NUNITS must be 1 to 8");
  end
  if (WR_TO < 2) begin : g_bad_timeout
    $error("WR_TO must be at least 2");
  end

  typedef struct packed {
    mtcu_st_t          st;
    mtcu_cmd_t         cmd;
    logic              cont;
    logic              seen;
    logic              alltm;
    logic [6:0]        lrc;
    logic              eof;
    logic              err;
    logic              gapseen;
    logic [NUNITS-1:0] eor;
    logic [TO_W-1:0]   tmr;
    logic [1:0]        eot_sh;
    logic              gap_p;
    logic              disc_p;
    logic              wstb;
    logic [6:0]        wchar;
    logic [DATA_W-1:0] rdata;
  } mtcu_state_t;

  mtcu_state_t s_r;
  mtcu_state_t s_nxt;
  mtcu_cmd_t   wcmd;
  logic        cmd_wr;
  logic        moving;
  logic        is_wr_op;
  logic        gap_take;
  logic        asm_clr;

  function automatic logic mtcu_parity(input logic [CHR_W-1:0] d, input logic bcd);
    mtcu_parity = bcd ? ^d : ~^d;
  endfunction : mtcu_parity

  function automatic logic mtcu_wr_op(input mtcu_op_t op);
    mtcu_wr_op = (op == OP_WRITE) || (op == OP_ERASE);
  endfunction : mtcu_wr_op

  assign wcmd     = mtcu_cmd_t'(bus_wdata[CMD_W-1:0]);
  assign cmd_wr   = bus_wr && (bus_addr == REG_CMD);
  assign moving   = (s_r.st != ST_IDLE);
  assign is_wr_op = mtcu_wr_op(s_r.cmd.op);
  assign gap_take = (s_r.st == ST_RUN) && tape_gap && s_r.seen;
  assign asm_clr  = cmd_wr && !moving;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt        = s_r;
    s_nxt.gap_p  = 1'b0;
    s_nxt.disc_p = 1'b0;
    s_nxt.wstb   = 1'b0;
    s_nxt.eot_sh = {s_r.eot_sh[0], 1'b0};
    s_nxt.rdata  = '0;
    if (bus_rd && bus_addr == REG_STAT) begin
      s_nxt.rdata[STAT_BUSY] = moving;
      s_nxt.rdata[STAT_EOF]  = s_r.eof;
      s_nxt.rdata[STAT_ERR]  = s_r.err;
      s_nxt.rdata[STAT_GAP]  = s_r.gapseen;
      s_nxt.rdata[STAT_EOR +: NUNITS] = s_r.eor;
    end
    if (cmd_wr) begin
      s_nxt.eof     = 1'b0;
      s_nxt.err     = 1'b0;
      s_nxt.gapseen = 1'b0;
    end
    // marker crossed forward sets, crossed backward clears
    if (moving && {1'b0, s_r.cmd.unit} < 4'(NUNITS) && eor_sense[s_r.cmd.unit]) begin
      s_nxt.eor[s_r.cmd.unit] = !s_r.cmd.rev;
    end
    case (s_r.st)
      ST_IDLE: begin
        if (cmd_wr) begin
          s_nxt.cmd   = wcmd;
          s_nxt.lrc   = '0;
          s_nxt.seen  = 1'b0;
          s_nxt.alltm = 1'b1;
          s_nxt.cont  = 1'b0;
          s_nxt.st    = mtcu_wr_op(wcmd.op) ? ST_WRITE : ST_RUN;
        end
      end
      ST_RUN: begin
        if (cmd_wr && !mtcu_wr_op(wcmd.op))
          s_nxt.cont = 1'b1;
        if (tape_rvalid) begin
          s_nxt.seen  = 1'b1;
          s_nxt.lrc   = s_r.lrc ^ tape_rchar;
          s_nxt.alltm = s_r.alltm && (tape_rchar == TAPE_MARK);
          if (tape_rchar[6] != mtcu_parity(tape_rchar[5:0], s_r.cmd.bcd))
            s_nxt.err = 1'b1;
        end
        if (gap_take) begin
          s_nxt.gap_p   = 1'b1;
          s_nxt.gapseen = 1'b1;
          // check character is in lrc, so a good record sums to zero
          if (s_r.lrc != 7'h00)
            s_nxt.err = 1'b1;
          if (s_r.alltm)
            s_nxt.eof = 1'b1;
          s_nxt.seen  = 1'b0;
          s_nxt.lrc   = '0;
          s_nxt.alltm = 1'b1;
          // a continue never carries past a tape mark record
          s_nxt.cont = 1'b0;
          if (s_r.cont && !s_r.alltm) begin
            s_nxt.st     = ST_RUN;
          end else begin
            s_nxt.st     = ST_IDLE;
            s_nxt.disc_p = 1'b1;
            s_nxt.eot_sh = {s_r.eot_sh[0], s_r.cmd.ie};
          end
        end
      end
      ST_WRITE: begin
        if (ch_char_valid) begin
          s_nxt.wstb  = (s_r.cmd.op == OP_WRITE);
          s_nxt.wchar = {mtcu_parity(ch_char, s_r.cmd.bcd), ch_char};
          s_nxt.lrc   = s_r.lrc ^ {mtcu_parity(ch_char, s_r.cmd.bcd), ch_char};
        end
        if (ch_term)
          s_nxt.st = ST_WTAIL;
      end
      ST_WTAIL: begin
        s_nxt.wstb  = (s_r.cmd.op == OP_WRITE);
        s_nxt.wchar = s_r.lrc;
        s_nxt.st    = ST_WECHO;
      end
      ST_WECHO: begin
        // erase writes no check character, so no echo ever comes back
        if (tape_raw_chk || s_r.cmd.op == OP_ERASE) begin
          s_nxt.gap_p   = 1'b1;
          s_nxt.gapseen = 1'b1;
          s_nxt.tmr     = '0;
          s_nxt.st      = ST_WGAP;
        end
      end
      ST_WGAP: begin
        s_nxt.tmr = s_r.tmr + TO_W'(1);
        if (cmd_wr && mtcu_wr_op(wcmd.op)) begin
          s_nxt.cmd = wcmd;
          s_nxt.lrc = '0;
          s_nxt.st  = ST_WRITE;
        end else if (s_r.tmr == TO_W'(WR_TO - 1)) begin
          s_nxt.st     = ST_IDLE;
          s_nxt.disc_p = 1'b1;
          s_nxt.eot_sh = {s_r.eot_sh[0], s_r.cmd.ie};
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.alltm <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data bits pass unchanged, so a tape mark record reads as 17170000
  mtcu_asm u_asm (
    .clk        (clk),
    .rst_n      (rst_n),
    .clr        (asm_clr),
    .chr_valid  ((s_r.st == ST_RUN) && tape_rvalid),
    .chr        (tape_rchar[5:0]),
    .scan       (s_r.cmd.op == OP_SCAN),
    .cpw_m1     (s_r.cmd.cpw_m1),
    .flush      (gap_take),
    .word_valid (ch_word_valid),
    .word       (ch_word)
  );

  assign bus_rdata       = s_r.rdata;
  assign tape_fwd        = moving && !s_r.cmd.rev;
  assign tape_rev        = moving && s_r.cmd.rev;
  assign tape_unit       = s_r.cmd.unit;
  assign tape_rec        = (s_r.st == ST_WRITE || s_r.st == ST_WTAIL) && is_wr_op
                           && (s_r.cmd.op == OP_WRITE);
  assign tape_wstb       = s_r.wstb;
  assign tape_wchar      = s_r.wchar;
  assign ch_gap          = s_r.gap_p;
  assign ch_disc         = s_r.disc_p;
  assign ch_err          = s_r.err;
  assign ch_word_end_int = ch_word_valid && s_r.cmd.ie;
  assign ch_eot_int      = s_r.eot_sh[1];

  ////////////////////////////////////////////////////////////////////////////
  // status tests; an out-of-range unit number counts as absent
  logic u_ok;
  logic u_rdy;
  assign u_ok  = ({1'b0, test_unit} < 4'(NUNITS)) && unit_present[test_unit];
  assign u_rdy = u_ok && unit_auto[test_unit] && !unit_busy[test_unit]
                 && !(moving && s_r.cmd.unit == test_unit);

  always_comb begin
    test_skip = 1'b0;
    if (test_valid) begin
      case (test_kind)
        TK_READY: test_skip = !u_rdy;
        TK_RING:  test_skip = u_ok && unit_ring[test_unit];
        TK_LOAD:  test_skip = u_ok && !unit_load_pt[test_unit];
        TK_EOR:   test_skip = u_ok && !s_r.eor[test_unit];
        default:  test_skip = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_read_stop: assert property (gap_take && !s_r.cont && !cmd_wr
      |=> s_r.st == ST_IDLE && ch_disc && !tape_fwd && !tape_rev)
    else $error("read did not stop at gap");
  chk_eof_hold: assert property (s_r.eof && !cmd_wr |=> s_r.eof)
    else $error("eof dropped without command");
  chk_eof_set: assert property (gap_take && s_r.alltm |=> s_r.eof && !moving)
    else $error("eof not set on tape mark record");
  chk_lrc_err: assert property (gap_take && s_r.lrc != 7'h00 |=> ch_err)
    else $error("longitudinal error lost");
  chk_scan_words: assert property (s_r.cmd.op == OP_SCAN && ch_word_valid
      |-> $past(gap_take))
    else $error("scan produced a word before gap");
  chk_eot_order: assert property (ch_eot_int && s_r.cmd.op == OP_SCAN
      |-> $past(ch_word_valid))
    else $error("end interrupt not after word end");
  chk_tail_lrc: assert property (s_r.st == ST_WTAIL && s_r.cmd.op == OP_WRITE
      |=> tape_wstb && tape_wchar == $past(s_r.lrc))
    else $error("check character not written");
  chk_erase_quiet: assert property (s_r.cmd.op == OP_ERASE |-> !tape_rec && !tape_wstb)
    else $error("erase recorded data");
  chk_wgap_time: assert property (s_r.st == ST_WGAP && s_r.tmr == TO_W'(WR_TO - 1)
      && !cmd_wr |=> ch_disc && s_r.st == ST_IDLE)
    else $error("write gap timeout wrong");
  chk_ready_skip: assert property (test_valid && test_kind == TK_READY
      && (!u_ok || moving && s_r.cmd.unit == test_unit) |-> test_skip)
    else $error("not ready unit gave no skip");
  chk_absent_skip: assert property (test_valid && test_kind != TK_READY && !u_ok
      |-> !test_skip)
    else $error("absent unit skipped");
  chk_parity_err: assert property (s_r.st == ST_RUN && tape_rvalid
      && tape_rchar[6] != mtcu_parity(tape_rchar[5:0], s_r.cmd.bcd) |=> ch_err)
    else $error("character parity error lost");
  chk_erase_gap: assert property (s_r.st == ST_WECHO && s_r.cmd.op == OP_ERASE
      |=> ch_gap && s_r.st == ST_WGAP)
    else $error("erase did not reach gap");
  chk_eor_set: assert property (moving && !s_r.cmd.rev && eor_sense[s_r.cmd.unit]
      && {1'b0, s_r.cmd.unit} < 4'(NUNITS) |=> s_r.eor[$past(s_r.cmd.unit)])
    else $error("end-of-reel not set");
  chk_eor_clear: assert property (moving && s_r.cmd.rev && eor_sense[s_r.cmd.unit]
      && {1'b0, s_r.cmd.unit} < 4'(NUNITS) |=> !s_r.eor[$past(s_r.cmd.unit)])
    else $error("end-of-reel not cleared backward");
  chk_skip_idle: assert property (!test_valid |-> !test_skip)
    else $error("skip without a test");

  cov_read_stop:  cover property (gap_take && s_r.alltm ##1 ch_disc);
  cov_rev_scan:   cover property (ch_word_end_int && s_r.cmd.rev ##1 ch_eot_int);
  cov_write_gap:  cover property (s_r.st == ST_WECHO ##1 ch_gap);
  cov_rewrite:    cover property (s_r.st == ST_WGAP ##1 s_r.st == ST_WRITE);
  cov_continue:   cover property (gap_take && s_r.cont ##1 moving);

endmodule : mtcu_ctrl

// ==== hw/mtcu_pkg.sv ====
// constants, types and command layout of the tape control unit
package mtcu_pkg;

  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 16;
  localparam logic [3:0]  REG_CMD     = 4'h0;
  localparam logic [3:0]  REG_STAT    = 4'h4;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_EOF    = 1;
  localparam int          STAT_ERR    = 2;
  localparam int          STAT_GAP    = 3;
  localparam int          STAT_EOR    = 8;
  localparam int          CLK_KHZ     = 20000;
  localparam int          WR_TO_US    = 1000;
  localparam int          WR_TO_CYC   = (WR_TO_US * CLK_KHZ) / 1000;
  localparam logic [6:0]  TAPE_MARK   = 7'h0F;
  localparam int          CHR_W       = 6;
  localparam int          WORD_W      = 24;
  localparam int          CMD_W       = 10;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_SCAN  = 2'h1,
    OP_WRITE = 2'h2,
    OP_ERASE = 2'h3
  } mtcu_op_t;

  typedef enum logic [1:0] {
    TK_READY = 2'h0,
    TK_RING  = 2'h1,
    TK_LOAD  = 2'h2,
    TK_EOR   = 2'h3
  } mtcu_test_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RUN   = 3'h1,
    ST_WRITE = 3'h2,
    ST_WTAIL = 3'h3,
    ST_WECHO = 3'h4,
    ST_WGAP  = 3'h5
  } mtcu_st_t;

  // cpw_m1 holds characters per word minus one
  typedef struct packed {
    logic       ie;
    logic       rev;
    logic       bcd;
    logic [1:0] cpw_m1;
    logic [2:0] unit;
    mtcu_op_t   op;
  } mtcu_cmd_t;

endpackage : mtcu_pkg

// ==== hw/mtcu_asm.sv ====
// word assembly register: packs tape characters into channel words
`timescale 1ns/1ns
module mtcu_asm
  import mtcu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clr,
  input  wire logic              chr_valid,
  input  wire logic [CHR_W-1:0]  chr,
  input  wire logic              scan,
  input  wire logic [1:0]        cpw_m1,
  input  wire logic              flush,
  output logic                   word_valid,
  output logic [WORD_W-1:0]      word
);

  typedef struct packed {
    logic [WORD_W-1:0] sh;
    logic [1:0]        cnt;
    logic              full;
    logic              vld;
    logic [WORD_W-1:0] wd;
  } mtcu_asm_t;

  mtcu_asm_t s_r;
  mtcu_asm_t s_nxt;

  // left-justify n held characters, n in 1..4
  function automatic logic [WORD_W-1:0] mtcu_just(input logic [WORD_W-1:0] v,
                                                  input logic [2:0] n);
    mtcu_just = v << (CHR_W * (3'h4 - n));
  endfunction : mtcu_just

  always_comb begin
    s_nxt     = s_r;
    s_nxt.vld = 1'b0;
    if (clr) begin
      s_nxt.sh   = '0;
      s_nxt.cnt  = 2'h0;
      s_nxt.full = 1'b0;
    end else if (flush) begin
      // scan keeps only the last four characters shifted through
      if (scan) begin
        s_nxt.vld = 1'b1;
        s_nxt.wd  = s_r.full ? s_r.sh : mtcu_just(s_r.sh, {1'b0, s_r.cnt});
      end else if (s_r.cnt != 2'h0) begin
        s_nxt.vld = 1'b1;
        s_nxt.wd  = mtcu_just(s_r.sh, {1'b0, s_r.cnt});
      end
      s_nxt.sh   = '0;
      s_nxt.cnt  = 2'h0;
      s_nxt.full = 1'b0;
    end else if (chr_valid) begin
      s_nxt.sh  = {s_r.sh[WORD_W-CHR_W-1:0], chr};
      s_nxt.cnt = s_r.cnt + 2'h1;
      if (s_r.cnt == 2'h3)
        s_nxt.full = 1'b1;
      if (!scan && s_r.cnt == cpw_m1) begin
        s_nxt.vld = 1'b1;
        s_nxt.wd  = mtcu_just({s_r.sh[WORD_W-CHR_W-1:0], chr}, {1'b0, cpw_m1} + 3'h1);
        s_nxt.cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign word_valid = s_r.vld;
  assign word       = s_r.wd;

endmodule : mtcu_asm

// ==== test/mtcu_tape_model.sv ====
// tape transport model: plays queued records and echoes the written check character
`timescale 1ns/1ns
module mtcu_tape_model (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  tape_fwd,
  input  wire logic  tape_rev,
  input  wire logic  tape_wstb,
  output logic       tape_rvalid = 1'b0,
  output logic [6:0] tape_rchar = 7'h00,
  output logic       tape_gap = 1'b0,
  output logic       tape_raw_chk = 1'b0
);
  logic [6:0] rec[$];
  int         ph = 0;
  int         idle = 0;
  logic       live = 1'b0;
  logic       wseen = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    logic       v;
    logic       g;
    logic       k;
    logic [6:0] c;
    v = 1'b0;
    g = 1'b0;
    k = 1'b0;
    // idle data lines toggle so a stale character never looks valid
    c = ~tape_rchar;
    if (!rst_n || !(tape_fwd || tape_rev)) begin
      ph = 0;
      live = 1'b0;
      wseen = 1'b0;
      idle = 0;
    end else begin
      ph = ph + 1;
      if (ph % 3 == 0 && rec.size() > 0) begin
        v = 1'b1;
        c = rec.pop_front();
        live = 1'b1;
      end else if (ph % 3 == 0 && live) begin
        g = 1'b1;
        live = 1'b0;
      end
      if (tape_wstb) begin
        wseen = 1'b1;
        idle = 0;
      end else if (wseen) begin
        idle = idle + 1;
        // head trails the last strobe, which is the check character
        if (idle == 6) begin
          k = 1'b1;
          wseen = 1'b0;
        end
      end
    end
    tape_rvalid  <= v;
    tape_rchar   <= c;
    tape_gap     <= g;
    tape_raw_chk <= k;
  end

endmodule : mtcu_tape_model

// ==== test/tb_top.sv ====
// testbench: tape control unit against a behavioural model
`timescale 1ns/1ns
module tb_top
  import mtcu_pkg::*;
();
  localparam int WTO = 16;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [3:0]        bus_addr = 4'h0;
  logic [15:0]       bus_wdata = 16'h0000;
  logic              bus_wr = 1'b0;
  logic              bus_rd = 1'b0;
  logic [15:0]       bus_rdata;
  logic              test_valid = 1'b0;
  mtcu_test_t        test_kind = TK_READY;
  logic [2:0]        test_unit = 3'h0;
  logic              test_skip;
  logic [7:0]        pres = 8'hFF, aut = 8'hFF, ring = 8'hFF, lp = 8'h00, bsy = 8'h00;
  logic [7:0]        eors = 8'h00;
  logic [7:0]        eor_m = 8'h00;
  logic              tape_fwd, tape_rev, tape_rec, tape_wstb, tape_rvalid, tape_gap;
  logic              tape_raw_chk, ch_word_valid, ch_gap, ch_disc, ch_weint, ch_eot, ch_err;
  logic [2:0]        tape_unit;
  logic [6:0]        tape_wchar, tape_rchar;
  logic [23:0]       ch_word;
  logic              ch_char_valid = 1'b0;
  logic [5:0]        ch_char = 6'h00;
  logic              ch_term = 1'b0;
  logic [23:0]       words[$];
  logic [6:0]        wch[$];
  logic [6:0]        rec[$];
  logic [15:0]       rv;
  logic              mv = 1'b0;
  int                err_count = 0;
  int                n_checks = 0;
  int                cyc = 0, n_disc = 0, n_rec = 0, gap_t = 0, disc_t = 0, eot_t = 0, we_t = 0;

  always #25 clk = ~clk;

  mtcu_ctrl #(.NUNITS(8), .WR_TO(WTO)) u_dut (
    .clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .test_valid, .test_kind, .test_unit, .test_skip,
    .unit_present(pres), .unit_auto(aut), .unit_ring(ring), .unit_load_pt(lp),
    .unit_busy(bsy), .eor_sense(eors), .tape_fwd, .tape_rev, .tape_unit, .tape_rec,
    .tape_wstb, .tape_wchar, .tape_rvalid, .tape_rchar, .tape_gap, .tape_raw_chk,
    .ch_word_valid, .ch_word, .ch_char_valid, .ch_char, .ch_term, .ch_gap, .ch_disc,
    .ch_err, .ch_word_end_int(ch_weint), .ch_eot_int(ch_eot));

  mtcu_tape_model u_tape (
    .clk, .rst_n, .tape_fwd, .tape_rev, .tape_wstb,
    .tape_rvalid, .tape_rchar, .tape_gap, .tape_raw_chk);

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (ch_word_valid) words.push_back(ch_word);
    if (tape_wstb) wch.push_back(tape_wchar);
    if (tape_rec) n_rec++;
    if (ch_gap) gap_t = cyc;
    if (ch_disc) disc_t = cyc;
    if (ch_disc) n_disc++;
    if (ch_eot) eot_t = cyc;
    if (ch_weint) we_t = cyc;
    cyc++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
    @(posedge clk);
  endtask : rd

  function automatic logic [15:0] cmd(input mtcu_op_t op, input logic [2:0] u,
                                      input logic r, input logic ie);
    mtcu_cmd_t c;
    c = '{ie, r, 1'b1, 2'h3, u, op};
    return {6'h00, c};
  endfunction : cmd

  function automatic logic exp_skip();
    int u;
    u = test_unit;
    case (test_kind)
      TK_READY: return !(pres[u] && aut[u] && !bsy[u] && !mv);
      TK_RING:  return pres[u] && ring[u];
      TK_LOAD:  return pres[u] && !lp[u];
      default:  return pres[u] && !eor_m[u];
    endcase
  endfunction : exp_skip

  function automatic logic [23:0] w4(input int o);
    logic [23:0] w;
    w = 24'h000000;
    for (int i = 0; i < 4; i++) begin
      if (o + i < rec.size()) w[23-6*i -: 6] = rec[o+i][5:0];
    end
    return w;
  endfunction : w4

  // even parity on top, then the longitudinal sum so the whole record xors to zero
  task automatic mkrec(input int n);
    logic [5:0] d;
    logic [6:0] l;
    rec = {};
    l = 7'h00;
    for (int i = 0; i < n; i++) begin
      d = 6'($urandom);
      rec.push_back({^d, d});
      l = l ^ rec[i];
    end
    rec.push_back(l);
  endtask : mkrec

  task automatic tst(input mtcu_test_t k, input logic [2:0] u);
    test_kind  <= k;
    test_unit  <= u;
    test_valid <= 1'b1;
    @(negedge clk);
    chk("skip", 32'(test_skip), 32'(exp_skip()));
    @(posedge clk);
  endtask : tst

  task automatic wait_disc(input int k);
    for (int i = 0; i < 400 && n_disc < k; i++) begin
      @(posedge clk);
    end
    if (n_disc < k) begin
      err_count++;
      complete_run();
    end
    repeat (3) @(posedge clk);
  endtask : wait_disc

  task automatic chk_stat(input logic eof, input logic err);
    rd(REG_STAT, rv);
    chk("stat", 32'(rv), 32'({eor_m, 4'h0, 1'b1, err, eof, 1'b0}));
    chk("ch_err", 32'(ch_err), 32'(err));
  endtask : chk_stat

  task automatic run_rd(input logic [15:0] c, input logic [2:0] u, input logic r);
    int k;
    k = n_disc;
    words = {};
    eot_t = 0;
    we_t = 0;
    foreach (rec[i]) u_tape.rec.push_back(r ? rec[rec.size() - 1 - i] : rec[i]);
    wr(REG_CMD, c);
    @(posedge clk);
    chk("motion", 32'({tape_fwd, tape_rev, tape_unit}), 32'({!r, r, u}));
    eors[u] <= 1'b1;
    mv = 1'b1;
    tst(TK_READY, u);
    mv = 1'b0;
    eors[u] <= 1'b0;
    eor_m[u] = !r;
    wait_disc(k + 1);
  endtask : run_rd

  task automatic run_wr(input mtcu_op_t op, input int n, input logic r);
    int k;
    k = n_disc;
    wch = {};
    n_rec = 0;
    mkrec(n);
    if (n == 1) rec = {TAPE_MARK, TAPE_MARK};
    tst(TK_READY, 3'h4);
    tst(TK_RING, 3'h4);
    wr(REG_CMD, cmd(op, 3'h4, r, 1'b0));
    for (int i = 0; i < n; i++) begin
      ch_char_valid <= 1'b1;
      ch_char       <= rec[i][5:0];
      @(posedge clk);
      ch_char_valid <= 1'b0;
      @(posedge clk);
    end
    ch_term <= 1'b1;
    @(posedge clk);
    ch_term <= 1'b0;
    wait_disc(k + 1);
    chk("disc_delay", disc_t - gap_t, WTO);
    chk("wr_count", wch.size(), op == OP_WRITE ? n + 1 : 0);
    chk("rec_on", n_rec > 0, op == OP_WRITE);
    foreach (wch[i]) chk("wchar", 32'(wch[i]), 32'(rec[i]));
  endtask : run_wr

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_STAT, rv);
    chk("stat_rst", 32'(rv), 32'h0);
    rd(4'h8, rv);
    chk("unmapped", 32'(rv), 32'h0);
    for (int i = 0; i < 48; i++) begin
      {pres, aut, ring, lp, bsy} <= 40'({$urandom, $urandom});
      tst(mtcu_test_t'(i[1:0]), 3'($urandom));
    end
    {pres, aut, ring, lp, bsy} <= 40'hFF_FF_FF_00_00;
    // end-of-file record: tape mark plus its check character
    rec = {TAPE_MARK, TAPE_MARK};
    run_rd(cmd(OP_READ, 3'h1, 1'b0, 1'b0), 3'h1, 1'b0);
    chk("eof_words", words.size(), 1);
    chk("eof_word", 32'(words[0]), 32'h3CF000);
    chk_stat(1'b1, 1'b0);
    tst(TK_EOR, 3'h1);
    for (int j = 0; j < 3; j++) begin
      mkrec(5);
      if (j == 1) rec[5] = rec[5] ^ 7'h41;
      if (j == 2) rec[0] = rec[0] ^ 7'h40;
      run_rd(cmd(OP_READ, 3'h2, 1'b0, 1'b0), 3'h2, 1'b0);
      chk("rd_w0", 32'(words[0]), 32'(w4(0)));
      chk("rd_w1", 32'(words[1]), 32'(w4(4)));
      chk_stat(1'b0, j > 0);
    end
    // continue command rides through the first gap to a second record
    mkrec(3);
    words = {};
    gap_t = 0;
    foreach (rec[i]) u_tape.rec.push_back(rec[i]);
    wr(REG_CMD, cmd(OP_READ, 3'h2, 1'b0, 1'b0));
    @(posedge clk);
    wr(REG_CMD, cmd(OP_READ, 3'h2, 1'b0, 1'b0));
    for (int i = 0; i < 100 && gap_t == 0; i++) begin
      @(posedge clk);
    end
    chk("cont_gap", 32'(gap_t > 0), 32'h1);
    foreach (rec[i]) u_tape.rec.push_back(rec[i]);
    repeat (2) @(posedge clk);
    chk("cont_run", 32'(tape_fwd), 32'h1);
    wait_disc(n_disc + 1);
    chk("cont_words", words.size(), 2);
    mkrec(6);
    run_rd(cmd(OP_SCAN, 3'h3, 1'b0, 1'b0), 3'h3, 1'b0);
    chk("scan_n", words.size(), 1);
    chk("scan_fwd", 32'(words[0]), 32'(w4(3)));
    mkrec(6);
    run_rd(cmd(OP_SCAN, 3'h1, 1'b1, 1'b1), 3'h1, 1'b1);
    chk("scan_rev", 32'(words[0]),
        32'({rec[3][5:0], rec[2][5:0], rec[1][5:0], rec[0][5:0]}));
    chk("eot_at", eot_t - disc_t, 1);
    chk("int_order", we_t > 0 && we_t < eot_t, 1);
    tst(TK_EOR, 3'h1);
    tst(TK_READY, 3'h1);
    run_wr(OP_WRITE, 4, 1'b0);
    run_wr(OP_ERASE, 4, 1'b1);
    run_wr(OP_WRITE, 1, 1'b0);
    run_wr(OP_ERASE, 4 * 150, 1'b0);
    complete_run();
  end

endmodule : tb_top
